// >>> i2cp_port.v
`timescale 1ns/1ns
`include "i2cp_defines.vh"
module i2cp_port #(
  parameter PAGE_W = 2
) (
  input wire CLK,        // System clock, 20 MHz
  input wire RST_B,      // Asynchronous reset, active low
  input wire SCL_I,      // Bus clock from master
  input wire SDA_I,      // Bus data level
  output reg SDA_O,      // Data output value, always low
  output reg SDA_OE,     // High while pulling data low
  input wire ADDR_SELECT_HIGH_PIN, // Address select, high bit
  input wire ADDR_SELECT_LOW_PIN,  // Address select, low bit
  output reg [7:0] PAGE, // Selected page
  output reg [7:0] BOOK, // Selected book
  output reg BUSY        // Transaction addressed to us
);
  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_ADDR = 10'h002;
  localparam [9:0] S_AACK = 10'h004;
  localparam [9:0] S_REG = 10'h008;
  localparam [9:0] S_RACK = 10'h010;
  localparam [9:0] S_WDATA = 10'h020;
  localparam [9:0] S_WACK = 10'h040;
  localparam [9:0] S_RDATA = 10'h080;
  localparam [9:0] S_MACK = 10'h100;
  localparam [9:0] S_IGNORE = 10'h200;

  localparam [1:0] K_MEM = 2'h0;
  localparam [1:0] K_PAGE = 2'h1;
  localparam [1:0] K_BOOK = 2'h2;

  reg rst_meta_q;
  reg rst_n_q;
  wire [3:0] sync_w;
  wire scl_s;
  wire sda_s;
  wire [1:0] adr_s;
  reg scl_q;
  reg sda_q;
  reg [9:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [6:0] idx_q;
  reg rw_q;
  reg mack_q;
  reg [7:0] rd_val;
  wire [7:0] mem_rdata;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire byte_done;
  wire mem_we;
  wire [1:0] wr_kind;

  // Index decode shared by read and write paths
  function [1:0] reg_kind;
    input [6:0] idx;
    input [7:0] page;
    begin
      if (idx == `I2CP_REG_PAGE)
        reg_kind = K_PAGE;
      else if (idx == `I2CP_REG_BOOK && page == `I2CP_BOOK_PAGE)
        reg_kind = K_BOOK;
      else
        reg_kind = K_MEM;
    end
  endfunction

  function [6:0] idx_next;
    input [6:0] idx;
    begin
      if (idx == `I2CP_IDX_LAST)
        idx_next = `I2CP_IDX_FIRST;
      else
        idx_next = idx + 7'h01;
    end
  endfunction

  // Reset released through two flops
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Bus lines and select pins are asynchronous to CLK
  i2cp_sync #(
    .W(4),
    .INIT(4'hf)
  ) u_sync (
    .clk(CLK),
    .rst_n(rst_n_q),
    .din({SCL_I, SDA_I, ADDR_SELECT_HIGH_PIN, ADDR_SELECT_LOW_PIN}),
    .dout(sync_w)
  );

  assign scl_s = sync_w[3];
  assign sda_s = sync_w[2];
  assign adr_s = sync_w[1:0];

  always @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
  assign byte_done = scl_fall & (cnt_q == `I2CP_BYTE_BITS);

  assign wr_kind = reg_kind(idx_q, PAGE);
  assign mem_we = (state_q == S_WDATA) & byte_done & (wr_kind == K_MEM);

  i2cp_regmem #(
    .AW(PAGE_W + 7),
    .DW(8)
  ) u_mem (
    .clk(CLK),
    .we(mem_we),
    .addr({PAGE[PAGE_W-1:0], idx_q}),
    .wdata(shift_q),
    .rdata(mem_rdata)
  );

  always @*
  begin
    case (reg_kind(idx_q, PAGE))
      K_PAGE: rd_val = PAGE;
      K_BOOK: rd_val = BOOK;
      default: rd_val = mem_rdata;
    endcase
  end

  always @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= `I2CP_IDX_FIRST;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
      PAGE <= `I2CP_PAGE_RST;
      BOOK <= `I2CP_BOOK_RST;
      BUSY <= 1'b0;
    end
    else if (start_det)
    begin
      // Repeated start lands here too
      state_q <= S_ADDR;
      cnt_q <= 4'h0;
      SDA_OE <= 1'b0;
      BUSY <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= S_IDLE;
      SDA_OE <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_ADDR, S_REG, S_WDATA:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_q <= 4'h0;
            if (state_q == S_ADDR)
            begin
              if (shift_q[7:1] == {`I2CP_ADDR_HI, adr_s})
              begin
                rw_q <= shift_q[0];
                SDA_OE <= 1'b1;
                BUSY <= 1'b1;
                state_q <= S_AACK;
              end
              else
              begin
                state_q <= S_IGNORE;
              end
            end
            else if (state_q == S_REG)
            begin
              idx_q <= shift_q[6:0];
              SDA_OE <= 1'b1;
              state_q <= S_RACK;
            end
            else
            begin
              if (wr_kind == K_BOOK)
                BOOK <= shift_q;
              if (wr_kind == K_PAGE)
                PAGE <= shift_q;
              idx_q <= idx_next(idx_q);
              SDA_OE <= 1'b1;
              state_q <= S_WACK;
            end
          end
        end
        S_AACK:
        begin
          if (scl_fall)
          begin
            if (rw_q)
            begin
              tx_q <= rd_val;
              SDA_OE <= ~rd_val[7];
              state_q <= S_RDATA;
            end
            else
            begin
              SDA_OE <= 1'b0;
              state_q <= S_REG;
            end
          end
        end
        S_RACK, S_WACK:
        begin
          if (scl_fall)
          begin
            SDA_OE <= 1'b0;
            state_q <= S_WDATA;
          end
        end
        S_RDATA:
        begin
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            idx_q <= idx_next(idx_q);
            cnt_q <= 4'h0;
            SDA_OE <= 1'b0;
            state_q <= S_MACK;
          end
          else if (scl_fall)
          begin
            SDA_OE <= ~tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        S_MACK:
        begin
          if (scl_rise)
          begin
            mack_q <= ~sda_s;
          end
          else if (scl_fall)
          begin
            if (mack_q)
            begin
              tx_q <= rd_val;
              SDA_OE <= ~rd_val[7];
              state_q <= S_RDATA;
            end
            else
            begin
              state_q <= S_IGNORE;
            end
          end
        end
        S_IGNORE, S_IDLE:
        begin
          SDA_OE <= 1'b0;
        end
        default:
        begin
          state_q <= S_IDLE;
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> i2cp_defines.vh
`ifndef I2CP_DEFINES_VH
`define I2CP_DEFINES_VH

// Fixed upper five bits of the 7-bit slave address
`define I2CP_ADDR_HI 5'h13
// Page selector, present on every page
`define I2CP_REG_PAGE 7'h00
// Book selector, present on page zero only
`define I2CP_REG_BOOK 7'h7f
// Last index inside a page, wraps to zero
`define I2CP_IDX_LAST 7'h7f
`define I2CP_IDX_FIRST 7'h00
// Page whose last register selects the book
`define I2CP_BOOK_PAGE 8'h00
`define I2CP_PAGE_RST 8'h00
`define I2CP_BOOK_RST 8'h00
// Bits per byte on the wire
`define I2CP_BYTE_BITS 4'h8

`endif

// >>> i2cp_sync.v
`timescale 1ns/1ns
module i2cp_sync #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk,          // System clock
  input wire rst_n,        // Synchronous-domain reset, active low
  input wire [W-1:0] din,  // Asynchronous inputs
  output reg [W-1:0] dout  // Synchronised copy
);
  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// >>> i2cp_regmem.v
`timescale 1ns/1ns
module i2cp_regmem #(
  parameter AW = 9,
  parameter DW = 8
) (
  input wire clk,            // System clock
  input wire we,             // Write strobe, one cycle
  input wire [AW-1:0] addr,  // Shared read and write address
  input wire [DW-1:0] wdata, // Write data
  output reg [DW-1:0] rdata  // Registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: contents are undefined until software writes them
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// >>> i2cp_chk.sv
`timescale 1ns/1ns
module i2cp_chk (
  input wire CLK, // Clock
  input wire RST_B, // Reset
  input wire SCL_I, // Bus clock
  input wire SDA_I, // Bus data
  input wire SDA_O, // Data value
  input wire SDA_OE, // Data drive
  input wire ADDR_SELECT_HIGH_PIN, // Strap
  input wire ADDR_SELECT_LOW_PIN, // Strap
  input wire [7:0] PAGE, // Page
  input wire [7:0] BOOK, // Book
  input wire BUSY // Busy
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_start;
    SCL_I && $fell(SDA_I);
  endsequence
  sequence s_stop;
    SCL_I && $rose(SDA_I);
  endsequence
  a_sda_zero: assert property (SDA_O == 1'b0)
    else $error("data value not low");
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
    else $error("data moved while clock high");
  a_oe_needs_busy: assert property (SDA_OE |-> BUSY)
    else $error("drive without address match");
  a_busy_ack: assert property ($rose(BUSY) |-> SDA_OE)
    else $error("busy without acknowledge");
  a_oe_stands: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
    else $error("acknowledge cut short");
  a_stop_idle: assert property (s_stop |-> ##[1:6] !BUSY)
    else $error("busy after stop");
  a_start_idle: assert property (s_start |-> ##[1:6] !BUSY)
    else $error("busy after start");
  a_page_busy: assert property ($changed(PAGE) |-> BUSY)
    else $error("page moved while idle");
  a_book_page: assert property ($changed(BOOK) |-> BUSY && PAGE == 8'h00)
    else $error("book moved off page zero");
endmodule
bind i2cp_port i2cp_chk chk (.CLK(CLK), .RST_B(RST_B), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ADDR_SELECT_HIGH_PIN(ADDR_SELECT_HIGH_PIN),
  .ADDR_SELECT_LOW_PIN(ADDR_SELECT_LOW_PIN), .PAGE(PAGE), .BOOK(BOOK), .BUSY(BUSY));

// >>> i2cp_host.sv
`timescale 1ns/1ns
module i2cp_host (
  output logic scl, // Bus clock
  output logic oe, // Pulls data low
  input wire sda // Resolved data
);
  logic [7:0] rd;
  logic ack;
  event ack_ev;
  event rd_ev;
  initial
  begin
    scl = 1'b1;
    oe = 1'b0;
  end
  // Data moves only in the low phase
  task clk_bit(input logic b, output logic s);
    begin
      #100 oe = !b;
      #100 scl = 1'b1;
      #100 s = sda;
      #100 scl = 1'b0;
    end
  endtask
  task start;
    begin
      #100 oe = 1'b0;
      #100 scl = 1'b1;
      #100 oe = 1'b1;
      #100 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #100 oe = 1'b1;
      #100 scl = 1'b1;
      #100 oe = 1'b0;
      #100;
    end
  endtask
  task wbyte(input logic [7:0] d);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(d[i], s);
      clk_bit(1'b1, ack);
      -> ack_ev;
    end
  endtask
  task rbyte(input logic last);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(1'b1, rd[i]);
      clk_bit(last, s);
      -> rd_ev;
    end
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] ad, d1, d2, bk;
  logic ack_q[$];
  logic [7:0] rd_q[$];
  logic [31:0] rng = 32'h0000000d;
  int n_errors = 0;
  int compares = 0;
  wire scl, m_oe, sda_o, sda_oe, busy;
  wire [7:0] page, book;
  wire sda = ~(sda_oe | m_oe);
  always #25 clk = ~clk;
  i2cp_host host (.scl(scl), .oe(m_oe), .sda(sda));
  i2cp_port #(.PAGE_W(2)) dut (.CLK(clk), .RST_B(rst_b), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe),
    .ADDR_SELECT_HIGH_PIN(sel[1]), .ADDR_SELECT_LOW_PIN(sel[0]),
    .PAGE(page), .BOOK(book), .BUSY(busy));
  function logic [7:0] rnd;
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      rnd = rng[7:0];
    end
  endfunction
  task check_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      compares++;
      if (g !== e)
      begin
        $display("mismatch %s exp %h got %h", nm, e, g);
        n_errors++;
      end
    end
  endtask
  task check_ack(input logic e, input logic g);
    begin
      compares++;
      if (g !== e)
      begin
        $display("mismatch ack exp %b got %b", e, g);
        n_errors++;
      end
    end
  endtask
  task check_rd(input logic [7:0] e, input logic [7:0] g);
    begin
      compares++;
      if (g !== e)
      begin
        $display("mismatch read exp %h got %h", e, g);
        n_errors++;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(host.ack_ev) check_ack(ack_q.pop_front(), host.ack);
  always @(host.rd_ev) check_rd(rd_q.pop_front(), host.rd);
  task wr(input logic [7:0] d, input logic nak);
    begin
      ack_q.push_back(nak);
      host.wbyte(d);
    end
  endtask
  task rdb(input logic [7:0] e, input logic last);
    begin
      rd_q.push_back(e);
      host.rbyte(last);
    end
  endtask
  task go;
    begin
      @(posedge clk);
      #5;
      host.start;
    end
  endtask
  initial
  begin
    #2000000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #5 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    check_reg("page", 8'h00, page);
    check_reg("book", 8'h00, book);
    for (int p = 0; p < 4; p++)
      for (int a = 0; a < 4; a++)
      begin
        sel = p[1:0];
        go;
        wr({5'h13, a[1:0], 1'b0}, a != p);
        wr(8'h00, a != p);
        host.stop;
        // Stop is seen a few clocks after the line rises
        #200;
        check_reg("busy", 8'h00, {7'h00, busy});
      end
    ad = {5'h13, sel, 1'b0};
    d1 = rnd();
    d2 = rnd();
    bk = rnd();
    go;
    wr(ad, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h01, 1'b0);
    host.stop;
    check_reg("page", 8'h01, page);
    go;
    wr(ad, 1'b0);
    wr(8'h7e, 1'b0);
    wr(d1, 1'b0);
    wr(d2, 1'b0);
    wr(8'h01, 1'b0);
    host.stop;
    check_reg("page", 8'h01, page);
    check_reg("book", 8'h00, book);
    go;
    wr(ad, 1'b0);
    wr(8'h7e, 1'b0);
    host.start;
    wr(ad | 8'h01, 1'b0);
    rdb(d1, 1'b0);
    rdb(d2, 1'b0);
    rdb(8'h01, 1'b1);
    host.stop;
    go;
    wr(ad, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h00, 1'b0);
    host.stop;
    check_reg("page", 8'h00, page);
    go;
    wr(ad, 1'b0);
    wr(8'h7f, 1'b0);
    wr(bk, 1'b0);
    host.stop;
    check_reg("book", bk, book);
    go;
    wr(ad, 1'b0);
    wr(8'h7f, 1'b0);
    host.start;
    wr(ad | 8'h01, 1'b0);
    rdb(bk, 1'b0);
    rdb(8'h00, 1'b1);
    host.stop;
    print_verdict;
  end
endmodule
